// [src/dpr_pkg.sv]
package dpr_pkg;
   localparam int DATA_W = 36;
   localparam int IDX_W = 10;
   localparam int HALF_W = 9;
   localparam int ADDR_W = 11;
   localparam int DEPTH = 1024;

   typedef enum logic [1:0]
   {
      DPR_READ_FIRST = 2'b00,
      DPR_WRITE_FIRST = 2'b01,
      DPR_NO_CHANGE = 2'b10
   } dpr_wmode_t;

   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [11:0] DPR_CTRL_OFS = 12'h000;
   localparam logic [11:0] DPR_STAT_OFS = 12'h004;
   localparam int DPR_CTRL_W = 11;
   localparam logic [DPR_CTRL_W-1:0] DPR_CTRL_RST = 11'h000;
   localparam int DPR_SPLIT_BIT = 0;
   localparam int DPR_PIPE_BIT = 1;
   localparam int DPR_WMODE_LSB = 3;
   localparam int DPR_NOLATCH_BIT = 7;
   localparam int DPR_CAS_BIT = 9;
   localparam int DPR_STAT_SLEEP_BIT = 0;
   localparam int DPR_STAT_SPLIT_BIT = 1;
endpackage

// [src/dpr_port_if.sv]
`timescale 1ns/1ns
interface dpr_port_if;
   import dpr_pkg::*;
   logic wr;
   logic [IDX_W-1:0] idx;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic pipe_en;
   dpr_wmode_t wmode;
   logic latch_off;
   logic cas_en;
   logic split;
   logic sleep;

   modport port
   (
      output wr, idx, wdata,
      input rdata, pipe_en, wmode, latch_off, cas_en, split, sleep
   );
   modport core
   (
      input wr, idx, wdata,
      output rdata, pipe_en, wmode, latch_off, cas_en, split, sleep
   );
endinterface

// [src/dpr_port.sv]
`timescale 1ns/1ns
module dpr_port
   import dpr_pkg::*;
#(
   parameter logic PORT_ID = 1'b0
)
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_en,
   input wire logic i_we,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_din,
   input wire logic [DATA_W-1:0] i_cas_din,
   dpr_port_if.port bus,
   output logic [DATA_W-1:0] o_dout,
   output logic [DATA_W-1:0] o_cas_dout
);
   logic en_r;
   logic we_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] din_r;
   logic [DATA_W-1:0] first_r;
   logic acc;
   logic cas_sel;
   logic hold;
   logic [DATA_W-1:0] value;

   // -------------------------------------------------------------
   // input capture
   // -------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         en_r <= 1'b0;
         we_r <= 1'b0;
         din_r <= '0;
      end
      else
      begin
         en_r <= i_en;
         if (i_en)
         begin
            we_r <= i_we;
            din_r <= i_din;
         end
      end
   end

   // address held between operations unless latching is off
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         addr_r <= '0;
      else if (i_en || bus.latch_off)
         addr_r <= i_addr;
   end

   // -------------------------------------------------------------
   // access decode
   // -------------------------------------------------------------
   assign acc = en_r && !bus.sleep;
   assign cas_sel = bus.cas_en && addr_r[ADDR_W-1];
   assign bus.wr = acc && we_r && !cas_sel;
   assign bus.wdata = din_r;
   assign bus.idx = bus.split ? {PORT_ID, addr_r[HALF_W-1:0]}
                              : addr_r[IDX_W-1:0];
   assign hold = we_r && !cas_sel && (bus.wmode == DPR_NO_CHANGE);

   always_comb
   begin
      value = bus.rdata;
      if (cas_sel)
         value = i_cas_din;
      else if (we_r && bus.wmode == DPR_WRITE_FIRST)
         value = din_r;
   end

   // -------------------------------------------------------------
   // read data path
   // -------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         first_r <= '0;
      else if (acc && !hold)
         first_r <= value;
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         o_dout <= '0;
      else if (bus.pipe_en)
         o_dout <= first_r;
      else if (acc && !hold)
         o_dout <= value;
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         o_cas_dout <= '0;
      else if (acc && !cas_sel)
         o_cas_dout <= bus.rdata;
   end
endmodule

// [src/dpr_top.sv]
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module dpr_top
   import dpr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_sleep,
   input wire logic i_a_en,
   input wire logic i_a_we,
   input wire logic [ADDR_W-1:0] i_a_addr,
   input wire logic [DATA_W-1:0] i_a_din,
   input wire logic [DATA_W-1:0] i_a_cas_din,
   output logic [DATA_W-1:0] o_a_dout,
   output logic [DATA_W-1:0] o_a_cas_dout,
   input wire logic i_b_en,
   input wire logic i_b_we,
   input wire logic [ADDR_W-1:0] i_b_addr,
   input wire logic [DATA_W-1:0] i_b_din,
   input wire logic [DATA_W-1:0] i_b_cas_din,
   output logic [DATA_W-1:0] o_b_dout,
   output logic [DATA_W-1:0] o_b_cas_dout
);
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DPR_CTRL_W-1:0] ctrl_r;
   logic sleep_r;
   logic wr_pend_r;
   logic [11:0] wr_ofs_r;
   logic take;

   dpr_port_if pif_a ();
   dpr_port_if pif_b ();

   // -------------------------------------------------------------
   // bus slave
   // -------------------------------------------------------------
   assign take = i_hsel && i_hready && i_htrans[1];

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wr_pend_r <= 1'b0;
         wr_ofs_r <= 12'h000;
      end
      else
      begin
         wr_pend_r <= take && i_hwrite;
         wr_ofs_r <= i_haddr[11:0];
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         ctrl_r <= DPR_CTRL_RST;
      else if (wr_pend_r && wr_ofs_r == DPR_CTRL_OFS)
         ctrl_r <= i_hwdata[DPR_CTRL_W-1:0];
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         o_hrdata <= 32'h0000_0000;
      else if (take && !i_hwrite)
      begin
         o_hrdata <= 32'h0000_0000;
         if (i_haddr[11:0] == DPR_CTRL_OFS)
            o_hrdata <= {21'h00_0000, ctrl_r};
         else if (i_haddr[11:0] == DPR_STAT_OFS)
         begin
            o_hrdata[DPR_STAT_SLEEP_BIT] <= sleep_r;
            o_hrdata[DPR_STAT_SPLIT_BIT] <= ctrl_r[DPR_SPLIT_BIT];
         end
      end
   end

   // -------------------------------------------------------------
   // power gating and storage
   // -------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         sleep_r <= 1'b0;
      else
         sleep_r <= i_sleep;
   end

   // storage, the split bit and sleep are all the two ports share
   always_ff @(posedge i_clock)
   begin
      if (pif_a.wr)
         mem[pif_a.idx] <= pif_a.wdata;
      if (pif_b.wr)
         mem[pif_b.idx] <= pif_b.wdata;
   end

   // -------------------------------------------------------------
   // port configuration
   // -------------------------------------------------------------
   assign pif_a.rdata = mem[pif_a.idx];
   assign pif_b.rdata = mem[pif_b.idx];
   assign pif_a.split = ctrl_r[DPR_SPLIT_BIT];
   assign pif_b.split = ctrl_r[DPR_SPLIT_BIT];
   assign pif_a.sleep = sleep_r;
   assign pif_b.sleep = sleep_r;
   assign pif_a.pipe_en = ctrl_r[DPR_PIPE_BIT];
   assign pif_b.pipe_en = ctrl_r[DPR_PIPE_BIT+1];
   assign pif_a.wmode = dpr_wmode_t'(ctrl_r[DPR_WMODE_LSB+:2]);
   assign pif_b.wmode = dpr_wmode_t'(ctrl_r[DPR_WMODE_LSB+2+:2]);
   assign pif_a.latch_off = ctrl_r[DPR_NOLATCH_BIT];
   assign pif_b.latch_off = ctrl_r[DPR_NOLATCH_BIT+1];
   assign pif_a.cas_en = ctrl_r[DPR_CAS_BIT];
   assign pif_b.cas_en = ctrl_r[DPR_CAS_BIT+1];

   dpr_port #(.PORT_ID(1'b0)) u_port_a
   (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_en(i_a_en),
      .i_we(i_a_we),
      .i_addr(i_a_addr),
      .i_din(i_a_din),
      .i_cas_din(i_a_cas_din),
      .bus(pif_a.port),
      .o_dout(o_a_dout),
      .o_cas_dout(o_a_cas_dout)
   );

   dpr_port #(.PORT_ID(1'b1)) u_port_b
   (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_en(i_b_en),
      .i_we(i_b_we),
      .i_addr(i_b_addr),
      .i_din(i_b_din),
      .i_cas_din(i_b_cas_din),
      .bus(pif_b.port),
      .o_dout(o_b_dout),
      .o_cas_dout(o_b_cas_dout)
   );
endmodule

// [dv/dpr_top_assertions.sv]
`timescale 1ns/1ns
module dpr_top_chk
   import dpr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_sleep,
   input wire logic i_a_en,
   input wire logic i_a_we,
   input wire logic [ADDR_W-1:0] i_a_addr,
   input wire logic [DATA_W-1:0] i_a_din,
   input wire logic [DATA_W-1:0] i_a_cas_din,
   input wire logic [DATA_W-1:0] o_a_dout,
   input wire logic [DATA_W-1:0] o_a_cas_dout,
   input wire logic i_b_en,
   input wire logic i_b_we,
   input wire logic [ADDR_W-1:0] i_b_addr,
   input wire logic [DATA_W-1:0] o_b_dout,
   input wire logic [DATA_W-1:0] o_b_cas_dout
);
   logic [DPR_CTRL_W-1:0] cm;
   logic cw;
   logic sq;
   logic ok;
   logic ar;
   logic br;
   assign ok = !i_sleep && !sq;
   assign ar = i_a_en && ok && !(cm[9] && i_a_addr[10]);
   assign br = i_b_en && !i_b_we && ok && !(cm[10] && i_b_addr[10]);
   // copy of the control word, taken from the bus writes
   always_ff @(posedge i_clock or negedge i_nrst)
      if (!i_nrst)
         {cw, sq, cm} <= {2'b00, DPR_CTRL_RST};
      else
      begin
         sq <= i_sleep;
         if (i_hready)
            cw <= i_hsel && i_htrans[1] && i_hwrite
               && i_haddr[11:0] == DPR_CTRL_OFS;
         if (cw && i_hready)
            cm <= i_hwdata[DPR_CTRL_W-1:0];
      end
   default clocking dc @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);
   chk_a_idle_hold:
      assert property ((!i_a_en && !cw)[*2] ##1 (!cw)[*2]
      |-> $stable(o_a_dout)) else $error("a output moved while idle");
   chk_a_read_edge:
      assert property (ar && !i_a_we && !cm[1]
      |-> ##2 o_a_dout == o_a_cas_dout) else $error("a read late");
   chk_a_pipe_lat:
      assert property (ar && !i_a_we && cm[1]
      |-> ##3 o_a_dout == $past(o_a_cas_dout)) else $error("a pipe late");
   chk_b_read_edge:
      assert property (br && !cm[2]
      |-> ##2 o_b_dout == o_b_cas_dout) else $error("b read late");
   chk_a_cas_pass:
      assert property (i_a_en && ok && cm[9] && i_a_addr[10]
      && !cm[1] |-> ##2 o_a_dout == $past(i_a_cas_din))
      else $error("a cascade data wrong");
   chk_a_new_data:
      assert property (ar && i_a_we && cm[4:3] == 2'b01
      && !cm[1] |-> ##2 o_a_dout == $past(i_a_din, 2))
      else $error("a write first wrong");
   chk_a_keep_out:
      assert property (ar && i_a_we && cm[4:3] == 2'b10
      && !cm[1] |-> ##2 $stable(o_a_dout)) else $error("a no change moved");
   chk_sleep_gate:
      assert property (i_a_en && i_sleep && sq && !cm[1]
      |-> ##2 $stable(o_a_dout)) else $error("a access while asleep");
endmodule
bind dpr_top dpr_top_chk dpr_top_chk_inst (.*);

// [dv/dpr_user.sv]
`timescale 1ns/1ns
module dpr_user
   import dpr_pkg::*;
(
   input wire logic i_clock,
   output logic o_en,
   output logic o_we,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_din,
   output logic [DATA_W-1:0] o_cas_din,
   input wire logic [DATA_W-1:0] i_dout
);
   initial {o_en, o_we, o_addr, o_din, o_cas_din} = '0;
   // one access; the bench never aims both ports at one word at once
   task automatic acc(input logic we, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q1, q2);
      @(posedge i_clock);
      {o_en, o_we, o_addr, o_din, o_cas_din} <= {1'b1, we, ad, d, d};
      @(posedge i_clock);
      // released address and write data lines carry inverted values; cascade data is kept; enable and write go low
      {o_en, o_we, o_addr, o_din} <= {2'b00, ~ad, ~d};
      @(posedge i_clock);
      #1 q1 = i_dout;
      @(posedge i_clock);
      #1 q2 = i_dout;
   endtask
endmodule

// [dv/dpr_top_bench.sv]
`timescale 1ns/1ns
module dpr_top_bench;
   import dpr_pkg::*;
   logic i_clock = 1'b0, i_nrst = 1'b0, i_sleep = 1'b0;
   logic i_hsel = 1'b0, i_hwrite = 1'b0, i_hready, o_hreadyout, o_hresp;
   logic [1:0] i_htrans = 2'b00;
   logic [2:0] i_hsize = 3'b010;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, r;
   logic i_a_en, i_a_we, i_b_en, i_b_we;
   logic [ADDR_W-1:0] i_a_addr, i_b_addr;
   logic [DATA_W-1:0] i_a_din, i_a_cas_din, o_a_dout, o_a_cas_dout;
   logic [DATA_W-1:0] i_b_din, i_b_cas_din, o_b_dout, o_b_cas_dout, q1, q2;
   int miscompares = 0;
   int total_checks = 0;
   assign i_hready = o_hreadyout;
   always #5 i_clock = ~i_clock;
   dpr_top dpr_top_inst (.*);
   dpr_user user_a (.i_clock, .o_en(i_a_en), .o_we(i_a_we), .o_addr(i_a_addr),
      .o_din(i_a_din), .o_cas_din(i_a_cas_din), .i_dout(o_a_dout));
   dpr_user user_b (.i_clock, .o_en(i_b_en), .o_we(i_b_we), .o_addr(i_b_addr),
      .o_din(i_b_din), .o_cas_din(i_b_cas_din), .i_dout(o_b_dout));
   task automatic chk(input logic [DATA_W-1:0] s, e, input string n);
      total_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic ahb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge i_clock);
      {i_hsel, i_htrans, i_haddr, i_hwrite} <= {1'b1, 2'b10, 20'h0, a, w};
      do @(posedge i_clock); while (!o_hreadyout);
      {i_hsel, i_htrans, i_hwdata} <= {3'b000, d};
      do @(posedge i_clock); while (!o_hreadyout);
      r = o_hrdata;
      chk(36'(o_hresp), 36'h0, "okay response");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      miscompares++;
      print_verdict;
   end
   initial
   begin
      repeat (12) @(posedge i_clock);
      i_nrst <= 1'b1;
      ahb(1'b0, DPR_CTRL_OFS, 32'h0);
      chk(36'(r), 36'h0, "ctrl reset");
      ahb(1'b0, 12'h008, 32'h0);
      chk(36'(r), 36'h0, "unmapped read");
      $display("test reset done");
      user_a.acc(1'b1, 11'h005, 36'h111111111, q1, q2);
      user_b.acc(1'b0, 11'h005, 36'h0, q1, q2);
      chk(q1, 36'h111111111, "b sees a");
      user_a.acc(1'b1, 11'h005, 36'h222222222, q1, q2);
      chk(q1, 36'h111111111, "old word");
      chk(q2, 36'h111111111, "idle hold");
      $display("test shared done");
      ahb(1'b1, DPR_CTRL_OFS, 32'h8);
      user_a.acc(1'b1, 11'h007, 36'h333333333, q1, q2);
      chk(q1, 36'h333333333, "new word");
      ahb(1'b1, DPR_CTRL_OFS, 32'h10);
      user_a.acc(1'b1, 11'h007, 36'h444444444, q1, q2);
      chk(q1, 36'h333333333, "no change");
      user_a.acc(1'b0, 11'h007, 36'h0, q1, q2);
      chk(q1, 36'h444444444, "stored word");
      $display("test modes done");
      ahb(1'b1, DPR_CTRL_OFS, 32'h2);
      user_a.acc(1'b0, 11'h005, 36'h0, q1, q2);
      chk(q1, 36'h444444444, "pipe early");
      chk(q2, 36'h222222222, "pipe late");
      $display("test pipe done");
      ahb(1'b1, DPR_CTRL_OFS, 32'h1);
      user_a.acc(1'b1, 11'h003, 36'h555555555, q1, q2);
      user_b.acc(1'b1, 11'h003, 36'h666666666, q1, q2);
      user_a.acc(1'b0, 11'h003, 36'h0, q1, q2);
      chk(q1, 36'h555555555, "half a");
      user_b.acc(1'b0, 11'h003, 36'h0, q1, q2);
      chk(q1, 36'h666666666, "half b");
      ahb(1'b0, DPR_STAT_OFS, 32'h0);
      chk(36'(r), 36'h2, "split status");
      $display("test split done");
      ahb(1'b1, DPR_CTRL_OFS, 32'h200);
      user_a.acc(1'b1, 11'h405, 36'h777777777, q1, q2);
      chk(q1, 36'h777777777, "cascade in");
      ahb(1'b1, DPR_CTRL_OFS, 32'h0);
      user_a.acc(1'b0, 11'h005, 36'h0, q1, q2);
      chk(q1, 36'h222222222, "no local write");
      $display("test cascade done");
      @(posedge i_clock);
      i_sleep <= 1'b1;
      ahb(1'b0, DPR_STAT_OFS, 32'h0);
      chk(36'(r), 36'h1, "sleep status");
      user_a.acc(1'b1, 11'h005, 36'h888888888, q1, q2);
      chk(q1, 36'h222222222, "asleep");
      @(posedge i_clock);
      i_sleep <= 1'b0;
      ahb(1'b0, DPR_STAT_OFS, 32'h0);
      chk(36'(r), 36'h0, "awake status");
      user_a.acc(1'b0, 11'h005, 36'h0, q1, q2);
      chk(q1, 36'h222222222, "kept word");
      $display("test sleep done");
      print_verdict;
   end
endmodule
